// ---- common/map_lock_pkg.sv ----
`default_nettype none

package map_lock_pkg;

	// Register addresses as printed (4-bit address field of the serial frame)
	localparam logic [3:0] GEN_SELECT_ADDR = 4'h9;
	localparam logic [3:0] LOCK_CFG_ADDR   = 4'ha;

	// Reset values
	localparam logic [7:0] GEN_SELECT_RST  = 8'h00;
	localparam logic [7:0] LOCK_CFG_RST    = 8'h60;

	// Lock field position and codes
	localparam int         LOCK_LSB        = 5;
	localparam int         LOCK_MSB        = 7;
	localparam logic [2:0] LOCK_CODE       = 3'h6;
	localparam logic [2:0] UNLOCK_CODE     = 3'h3;

	// Other field positions in the lock and diagnosis register
	localparam int         WARN_BIT        = 2;
	localparam int         OL_WAIT_BIT     = 1;
	localparam int         EDGE_BIT        = 0;

	// Open-load wait times in ns and the clock period in ns
	localparam int         CLK_PERIOD_NS   = 5;
	localparam int         OL_WAIT_SHORT_NS = 58000;
	localparam int         OL_WAIT_LONG_NS  = 80000;
	localparam int         OL_WAIT_SHORT_CYC = OL_WAIT_SHORT_NS / CLK_PERIOD_NS;
	localparam int         OL_WAIT_LONG_CYC  = OL_WAIT_LONG_NS / CLK_PERIOD_NS;
	localparam int         OL_CNT_W        = 15;

	// One register write from the serial frame decoder
	typedef struct packed {
		logic       valid;
		logic [3:0] addr;
		logic [7:0] data;
	} reg_write_t;

	typedef enum logic {
		GEN_ZERO,
		GEN_ONE
	} gen_choice_t;

endpackage : map_lock_pkg

`default_nettype wire

// ---- rtl/openload_wait_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Counts the open-load wait before the diagnosis mux may switch
module openload_wait_timer
	import map_lock_pkg::*;
#(
	parameter int SHORT_CYC = OL_WAIT_SHORT_CYC,
	parameter int LONG_CYC  = OL_WAIT_LONG_CYC
) (
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic start_i,
	input  wire logic long_sel_i,
	output logic      expired_o
);

	initial begin
		if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC >= (1 << OL_CNT_W))
			$error("openload_wait_timer: bad cycle counts");
	end

	logic [OL_CNT_W-1:0] count_reg;
	logic                running_reg;
	logic [OL_CNT_W-1:0] limit;

	assign limit = long_sel_i ? OL_CNT_W'(LONG_CYC - 1) : OL_CNT_W'(SHORT_CYC - 1);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_reg   <= '0;
			running_reg <= 1'b0;
			expired_o   <= 1'b0;
		end else if (start_i) begin
			count_reg   <= '0;
			running_reg <= 1'b1;
			expired_o   <= 1'b0;
		end else if (running_reg) begin
			if (count_reg >= limit) begin
				running_reg <= 1'b0;
				expired_o   <= 1'b1;
			end else begin
				count_reg <= count_reg + OL_CNT_W'(1);
			end
		end
	end

endmodule // openload_wait_timer

`default_nettype wire

// ---- rtl/pwm_map_and_config_lock_regs.sv ----
// Contract
// RL1 - Each output selects generator zero on bit 0, generator one on bit 1.
// RL2 - Host also enables per-output PWM, else selection has no effect.
// RL3 - Writing lock code 110b to the lock field locks the device.
// RL4 - Locked: ignore all writes except lock field and clear bits.
// RL5 - Unlocked: lock codes other than 110b leave state unchanged.
// RL6 - Writing 011b unlocks; all register writes accepted again.
// RL7 - Locked: codes other than 011b keep the device locked.
// RL8 - Bit 2 reports read-only overheat warning; zero at reset, one after event.
// RL9 - Wait select picks 58 us (0, reset) or 80 us (1) open-load wait.
// RL10 - Bit 0 picks edge rate 1.3 V/us (0, reset) or 3 V/us (1).
// RL11 - Reset leaves lock field at unlock code, device unlocked.
`timescale 1ns/1ps
`default_nettype none

module pwm_map_and_config_lock_regs
	import map_lock_pkg::*;
#(
	parameter int N_OUT        = 8,
	parameter int OL_SHORT_CYC = OL_WAIT_SHORT_CYC,
	parameter int OL_LONG_CYC  = OL_WAIT_LONG_CYC
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire reg_write_t       wr_i,
	input  wire logic [3:0]       rd_addr_i,
	input  wire logic             overheat_event_i,
	input  wire logic             overheat_clear_i,
	input  wire logic             ol_start_i,
	input  wire logic [N_OUT-1:0] pwm_out_en_i,
	input  wire logic             pwm_gen0_i,
	input  wire logic             pwm_gen1_i,
	output logic [7:0]            rd_data_o,
	output logic [N_OUT-1:0]      gen_select_o,
	output logic [N_OUT-1:0]      pwm_drive_o,
	output logic                  locked_o,
	output logic                  overheat_warning_flag_o,
	output logic                  openload_wait_select_o,
	output logic                  edge_rate_select_o,
	output logic                  ol_mux_go_o
);

	initial begin
		if (N_OUT != 8)
			$error("pwm_map_and_config_lock_regs: N_OUT must be 8");
	end

	logic       ovh_s1_reg;
	logic       ovh_s2_reg;
	logic       wr_gen;
	logic       wr_cfg;
	logic [2:0] lock_field;
	logic       ol_expired;
	logic [7:0] cfg_view;

	// Selects one generator per output
	function automatic logic pick_gen(input logic sel, input logic g0, input logic g1);
		return (gen_choice_t'(sel) == GEN_ONE) ? g1 : g0;
	endfunction

	assign wr_gen     = wr_i.valid && wr_i.addr == GEN_SELECT_ADDR;
	assign wr_cfg     = wr_i.valid && wr_i.addr == LOCK_CFG_ADDR;
	assign lock_field = wr_i.data[LOCK_MSB:LOCK_LSB];

	// Overheat event comes from the analog side: synchronise first
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ovh_s1_reg <= 1'b0;
			ovh_s2_reg <= 1'b0;
		end else begin
			ovh_s1_reg <= overheat_event_i;
			ovh_s2_reg <= ovh_s1_reg;
		end
	end

	// RL3 RL5 RL6 RL7 RL11 lock state
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			locked_o <= 1'b0;
		end else if (wr_cfg) begin
			if (!locked_o && lock_field == LOCK_CODE)
				locked_o <= 1'b1;
			else if (locked_o && lock_field == UNLOCK_CODE)
				locked_o <= 1'b0;
		end
	end

	// RL1 RL4 selector bits, frozen while locked
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			gen_select_o <= GEN_SELECT_RST;
		else if (wr_gen && !locked_o)
			gen_select_o <= wr_i.data;
	end

	// RL4 RL9 RL10 config bits, frozen while locked
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			openload_wait_select_o <= LOCK_CFG_RST[OL_WAIT_BIT];
			edge_rate_select_o     <= LOCK_CFG_RST[EDGE_BIT];
		end else if (wr_cfg && !locked_o) begin
			openload_wait_select_o <= wr_i.data[OL_WAIT_BIT];
			edge_rate_select_o     <= wr_i.data[EDGE_BIT];
		end
	end

	// RL8 sticky warning; a new event wins over a clear
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			overheat_warning_flag_o <= LOCK_CFG_RST[WARN_BIT];
		else if (ovh_s2_reg)
			overheat_warning_flag_o <= 1'b1;
		else if (overheat_clear_i)
			overheat_warning_flag_o <= 1'b0;
	end

	// RL1 RL2 output routing
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pwm_drive_o <= '0;
		end else begin
			for (int i = 0; i < N_OUT; i++)
				pwm_drive_o[i] <= pwm_out_en_i[i] && pick_gen(gen_select_o[i], pwm_gen0_i, pwm_gen1_i);
		end
	end

	// Lock field reads back the code that matches the state
	assign cfg_view = {locked_o ? LOCK_CODE : UNLOCK_CODE, 2'b00,
		overheat_warning_flag_o, openload_wait_select_o, edge_rate_select_o};

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			rd_data_o <= 8'h00;
		else if (rd_addr_i == GEN_SELECT_ADDR)
			rd_data_o <= gen_select_o;
		else if (rd_addr_i == LOCK_CFG_ADDR)
			rd_data_o <= cfg_view;
		else
			rd_data_o <= 8'h00;
	end

	// RL9 wait timer
	openload_wait_timer #(
		.SHORT_CYC(OL_SHORT_CYC),
		.LONG_CYC (OL_LONG_CYC)
	) u_ol_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (ol_start_i),
		.long_sel_i(openload_wait_select_o),
		.expired_o (ol_expired)
	);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			ol_mux_go_o <= 1'b0;
		else
			ol_mux_go_o <= ol_expired;
	end

	// Lock enters on code 110b when unlocked
	lock_enter_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL3
		(wr_cfg && !locked_o && lock_field == LOCK_CODE) |=> locked_o)
		else $error("lock not entered");

	other_code_unlocked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL5
		(wr_cfg && !locked_o && lock_field != LOCK_CODE) |=> !locked_o)
		else $error("lock entered on wrong code");

	lock_leave_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL6
		(wr_cfg && locked_o && lock_field == UNLOCK_CODE) |=> !locked_o)
		else $error("unlock failed");

	stay_locked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL7
		(wr_cfg && locked_o && lock_field != UNLOCK_CODE) |=> locked_o)
		else $error("lock left on wrong code");

	map_frozen_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL4
		locked_o |=> $stable(gen_select_o) && $stable(edge_rate_select_o) && $stable(openload_wait_select_o))
		else $error("write accepted while locked");

	map_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL1
		(wr_gen && !locked_o) |=> gen_select_o == $past(wr_i.data))
		else $error("selector write lost");

	route_gen_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL1
		(pwm_out_en_i[0] && !gen_select_o[0]) |=> pwm_drive_o[0] == $past(pwm_gen0_i))
		else $error("output 0 not on generator zero");

	warn_sticky_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL8
		ovh_s2_reg |=> overheat_warning_flag_o)
		else $error("warning flag not set");

	// A clear may follow the event at once, so holding is checked apart from setting
	warn_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL8
		(overheat_warning_flag_o && !overheat_clear_i) |=> overheat_warning_flag_o)
		else $error("warning flag dropped without clear");

	lock_readback_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL11
		(rd_addr_i == LOCK_CFG_ADDR) |=>
		rd_data_o[LOCK_MSB:LOCK_LSB] == ($past(locked_o) ? LOCK_CODE : UNLOCK_CODE))
		else $error("lock field read back wrong");

	ol_restart_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL9
		ol_start_i |=> ##1 !ol_mux_go_o)
		else $error("open-load wait not restarted");

	edge_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RL10
		(wr_cfg && !locked_o) |=> edge_rate_select_o == $past(wr_i.data[EDGE_BIT]))
		else $error("edge rate write lost");

	reset_unlocked_a: assert property (@(posedge core_clk_i) // RL11
		$fell(sys_rst_i) |-> !locked_o && rd_data_o == 8'h00)
		else $error("not unlocked after reset");

	lock_seen_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(locked_o));
	unlock_seen_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $fell(locked_o));
	warn_seen_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(overheat_warning_flag_o));
	ol_go_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(ol_mux_go_o));
	locked_write_c: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) wr_cfg && locked_o);

endmodule // pwm_map_and_config_lock_regs

`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_model
	import map_lock_pkg::*;
(
	input  wire logic      core_clk_i,
	output var reg_write_t wr_o,
	output var logic [7:0] pwm_out_en_o
);
	initial begin
		wr_o = '0;
		pwm_out_en_o = 8'h00;
	end

	// Idle fields carry the inverse so a stale value never passes for a write
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		wr_o = '{valid: 1'b1, addr: a, data: d};
		@(negedge core_clk_i);
		wr_o = '{valid: 1'b0, addr: ~a, data: ~d};
	endtask

	task automatic en(input logic [7:0] e);
		@(negedge core_clk_i);
		pwm_out_en_o = e;
	endtask
endmodule // host_model

`default_nettype wire

// ---- verif/tb_pwm_map_and_config_lock_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_pwm_map_and_config_lock_regs
	import map_lock_pkg::*;
;
	logic       clk, rst, heat, heat_clr, ol_go, g0, g1;
	logic       lck, warn, olw, edg, mux;
	logic [3:0] ra;
	reg_write_t wr;
	logic [7:0] en, rdat, sel, drv, v;
	int         n_fail = 0;
	int         tests_run = 0;

	host_model host (.core_clk_i(clk), .wr_o(wr), .pwm_out_en_o(en));

	pwm_map_and_config_lock_regs #(.OL_SHORT_CYC(4), .OL_LONG_CYC(8)) DUT (
		.core_clk_i(clk), .sys_rst_i(rst), .wr_i(wr), .rd_addr_i(ra),
		.overheat_event_i(heat), .overheat_clear_i(heat_clr), .ol_start_i(ol_go),
		.pwm_out_en_i(en), .pwm_gen0_i(g0), .pwm_gen1_i(g1), .rd_data_o(rdat),
		.gen_select_o(sel), .pwm_drive_o(drv), .locked_o(lck), .overheat_warning_flag_o(warn),
		.openload_wait_select_o(olw), .edge_rate_select_o(edg), .ol_mux_go_o(mux));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic rd(input logic [3:0] a);
		@(negedge clk);
		ra = a;
		step(2);
		v = rdat;
	endtask

	task automatic t_reset();
		rd(4'h9); check(v, 8'h00);
		rd(4'ha); check(v, 8'h60);
		check({4'h0, lck, warn, olw, edg}, 8'h00);
	endtask

	// Generator one high, zero low, so the drive pattern mirrors the selector
	task automatic t_map();
		g0 = 1'b0; g1 = 1'b1;
		host.en(8'hff);
		host.wr(4'h9, 8'ha5); step(1);
		check(sel, 8'ha5);
		check(drv, 8'ha5);
		g0 = 1'b1; g1 = 1'b0; step(2);
		check(drv, 8'h5a);
		host.en(8'h0f); step(2);
		check(drv, 8'h0a);
	endtask

	task automatic t_lock();
		host.wr(4'ha, 8'h63);
		for (int k = 0; k < 8; k++) begin
			if (k == 6) continue;
			host.wr(4'ha, {k[2:0], 5'h03}); step(1);
			check({7'h0, lck}, 8'h00);
		end
		host.wr(4'ha, 8'hc3); step(1);
		check({7'h0, lck}, 8'h01);
		host.wr(4'h9, 8'hff); step(1);
		check(sel, 8'ha5);
		for (int k = 0; k < 8; k++) begin
			if (k == 3) continue;
			host.wr(4'ha, {k[2:0], 5'h00}); step(1);
			check({7'h0, lck}, 8'h01);
		end
		rd(4'ha); check(v, 8'hc3);
		host.wr(4'ha, 8'h60); step(1);
		check({7'h0, lck}, 8'h00);
		host.wr(4'h9, 8'h3c); step(1);
		check(sel, 8'h3c);
	endtask

	// Wait select 0 expires after 4 cycles, 1 after 8; the mux go follows one cycle later
	task automatic t_ol();
		for (int s = 0; s < 2; s++) begin
			host.wr(4'ha, {6'h18, s[0], 1'b1}); step(1);
			check({6'h0, olw, edg}, {6'h0, s[0], 1'b1});
			ol_go = 1'b1; step(1); ol_go = 1'b0;
			step(4); check({7'h0, mux}, 8'h00);
			step(4); check({7'h0, mux}, {7'h0, ~s[0]});
			step(4); check({7'h0, mux}, 8'h01);
		end
	endtask

	task automatic t_heat();
		host.wr(4'ha, 8'h66);
		rd(4'ha); check(v, 8'h62);
		heat = 1'b1; step(4); heat = 1'b0; step(2);
		rd(4'ha); check(v, 8'h66);
		heat_clr = 1'b1; step(1); heat_clr = 1'b0; step(2);
		check({7'h0, warn}, 8'h00);
	endtask

	initial begin
		rst = 1'b1; ra = 4'h0; heat = 1'b0; heat_clr = 1'b0;
		ol_go = 1'b0; g0 = 1'b0; g1 = 1'b0;
		step(12);
		rst = 1'b0;
		t_reset();
		t_map();
		t_lock();
		t_ol();
		t_heat();
		end_sim();
	end

	initial begin
		#20000;
		n_fail++;
		end_sim();
	end
endmodule // tb_pwm_map_and_config_lock_regs

`default_nettype wire
